// ---- hw/core_pkg.sv ----
// constants for the bit-test, indirect-call and clear-accumulator execution block
package core_pkg;
  localparam int APB_AW = 8;
  localparam int DATA_W = 32;
  localparam int PC_W = 10;
  localparam int INSN_W = 14;
  localparam int STACK_DEPTH = 8;
  localparam int FILE_DEPTH = 64;
  // register byte offsets
  localparam logic [APB_AW-1:0] OFF_INSN = 8'h00;
  localparam logic [APB_AW-1:0] OFF_ACCUM = 8'h04;
  localparam logic [APB_AW-1:0] OFF_TPTR = 8'h08;
  localparam logic [APB_AW-1:0] OFF_PC = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_STATUS = 8'h10;
  localparam logic [APB_AW-1:0] OFF_FIDX = 8'h14;
  localparam logic [APB_AW-1:0] OFF_FDATA = 8'h18;
  localparam logic [APB_AW-1:0] OFF_STACK = 8'h1c;
  localparam logic [APB_AW-1:0] OFF_CYCLES = 8'h20;
  // instruction word fields
  localparam int OP_LSB = 11;
  localparam int OP_W = 3;
  localparam int BIT_LSB = 8;
  localparam int BIT_W = 3;
  localparam int FILE_LSB = 0;
  localparam int FILE_W = 6;
  // status fields
  localparam int ST_ZERO = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_SQUASH = 2;
  localparam int ST_SP_LSB = 4;
  // reset values and program counter step
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [7:0] TPTR_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 10'h000;
  localparam logic ZERO_RST = 1'b0;
  localparam logic [PC_W-1:0] PC_STEP = 10'h001;
  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_TEST_CLR = 3'b001,
    OP_TEST_SET = 3'b010,
    OP_ICALL = 3'b011,
    OP_CLRACC = 3'b100
  } opcode_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RUN = 2'b01,
    S_FLUSH = 2'b10
  } state_t;
  typedef enum logic [3:0] {
    R_INSN = 4'b0000,
    R_ACCUM = 4'b0001,
    R_TPTR = 4'b0010,
    R_PC = 4'b0011,
    R_STATUS = 4'b0100,
    R_FIDX = 4'b0101,
    R_FDATA = 4'b0110,
    R_STACK = 4'b0111,
    R_CYCLES = 4'b1000,
    R_NONE = 4'b1111
  } reg_id_t;
endpackage

// ---- hw/stack_if.sv ----
// link between the execution core and the return stack
`timescale 1ns/1ps
`default_nettype none
interface stack_if #(parameter int PC_W = 10, parameter int SP_W = 3);
  logic push;
  logic [PC_W-1:0] push_data;
  logic [SP_W-1:0] sp;
  logic [SP_W-1:0] rd_idx;
  logic [PC_W-1:0] rd_data;
  modport core (output push, output push_data, output rd_idx, input sp, input rd_data);
  modport stack (input push, input push_data, input rd_idx, output sp, output rd_data);
endinterface
`default_nettype wire

// ---- hw/return_stack.sv ----
// return-address stack with a wrapping pointer
`timescale 1ns/1ps
`default_nettype none
module return_stack #(
  parameter int DEPTH = core_pkg::STACK_DEPTH,
  parameter int SP_W = 3
) (
  input wire logic mclk,
  input wire logic rstn,
  stack_if.stack stk
);
  logic [core_pkg::PC_W-1:0] mem [DEPTH];
  logic [SP_W-1:0] sp_q;

  if (DEPTH != (1 << SP_W))
  begin : g_bad_depth
    $error("stack depth must be two to the power of the pointer width");
  end

  // push writes the entry under the pointer, then the pointer advances
  always_ff @(posedge mclk)
  begin
    if (stk.push)
    begin
      mem[sp_q] <= stk.push_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sp_q <= '0;
    end
    else if (stk.push)
    begin
      sp_q <= sp_q + SP_W'(1);
    end
  end

  assign stk.sp = sp_q;
  assign stk.rd_data = mem[stk.rd_idx];

  a_stack_push: assert property (@(posedge mclk) disable iff (!rstn)
    stk.push |=> (sp_q == $past(sp_q) + SP_W'(1)) && (mem[$past(sp_q)] == $past(stk.push_data)))
    else $error("push did not store at pointer and advance");
endmodule // return_stack
`default_nettype wire

// ---- hw/bit_select.sv ----
// picks one bit of a file register byte
`timescale 1ns/1ps
`default_nettype none
module bit_select #(parameter int WIDTH = 8, parameter int IDX_W = 3) (
  input wire logic [WIDTH-1:0] byte_in,
  input wire logic [IDX_W-1:0] idx,
  output logic bit_out
);
  logic [WIDTH-1:0] hit;

  if (WIDTH > (1 << IDX_W))
  begin : g_bad_width
    $error("index too narrow for byte width");
  end

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_hit
    assign hit[i] = byte_in[i] && (idx == IDX_W'(i));
  end

  assign bit_out = |hit;
endmodule // bit_select
`default_nettype wire

// ---- hw/insn_exec.sv ----
// execution core for bit-test skips, indirect call and accumulator clear
//
// Overview of operation
// - test clear skips next when bit is 0
// - test set skips next when bit is 1
// - skip discards prefetched instruction, runs nop instead
// - indirect call pushes program counter plus one
// - call loads pc from pointer low bits, accumulator
// - push stores at pointer then pointer advances
// - clear accumulator zeroes it, sets zero flag
// - file index 0..63, bit position 0..7
`timescale 1ns/1ps
`default_nettype none
module insn_exec #(
  parameter int STACK_DEPTH = core_pkg::STACK_DEPTH
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [core_pkg::APB_AW-1:0] paddr,
  input wire logic [core_pkg::DATA_W-1:0] pwdata,
  output logic [core_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  if (STACK_DEPTH < 2 || STACK_DEPTH > 16)
  begin : g_bad_depth
    $error("stack depth must be 2 to 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic core_pkg::reg_id_t reg_of(input logic [core_pkg::APB_AW-1:0] a);
    if (a == core_pkg::OFF_INSN) return core_pkg::R_INSN;
    else if (a == core_pkg::OFF_ACCUM) return core_pkg::R_ACCUM;
    else if (a == core_pkg::OFF_TPTR) return core_pkg::R_TPTR;
    else if (a == core_pkg::OFF_PC) return core_pkg::R_PC;
    else if (a == core_pkg::OFF_STATUS) return core_pkg::R_STATUS;
    else if (a == core_pkg::OFF_FIDX) return core_pkg::R_FIDX;
    else if (a == core_pkg::OFF_FDATA) return core_pkg::R_FDATA;
    else if (a == core_pkg::OFF_STACK) return core_pkg::R_STACK;
    else if (a == core_pkg::OFF_CYCLES) return core_pkg::R_CYCLES;
    else return core_pkg::R_NONE;
  endfunction

  core_pkg::reg_id_t rid;
  core_pkg::state_t state_q;
  logic [core_pkg::DATA_W-1:0] prdata_q;
  logic [core_pkg::DATA_W-1:0] rd_val;
  logic [core_pkg::DATA_W-1:0] cycles_q;
  logic pready_q;
  logic pslverr_q;
  logic busy;
  logic stall;
  logic done;
  logic wr_done;
  logic [core_pkg::INSN_W-1:0] insn_q;
  logic [7:0] accum_q;
  logic [7:0] tptr_q;
  logic [core_pkg::PC_W-1:0] pc_q;
  logic zero_q;
  logic squash_q;
  logic [core_pkg::FILE_W-1:0] fidx_q;
  logic [7:0] file_mem [core_pkg::FILE_DEPTH];
  core_pkg::opcode_t op;
  logic [core_pkg::FILE_W-1:0] f_addr;
  logic [core_pkg::BIT_W-1:0] f_bit;
  logic tbit;
  logic live;
  logic do_skip;

  stack_if #(.PC_W(core_pkg::PC_W), .SP_W(SP_W)) stk ();

  assign rid = reg_of(paddr);
  assign busy = (state_q != core_pkg::S_IDLE);
  // writes wait while an instruction executes
  assign stall = pwrite && busy;
  assign done = psel && penable && pready_q;
  assign wr_done = done && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer registered
  always_comb
  begin
    rd_val = '0;
    if (rid == core_pkg::R_INSN) rd_val[core_pkg::INSN_W-1:0] = insn_q;
    else if (rid == core_pkg::R_ACCUM) rd_val[7:0] = accum_q;
    else if (rid == core_pkg::R_TPTR) rd_val[7:0] = tptr_q;
    else if (rid == core_pkg::R_PC) rd_val[core_pkg::PC_W-1:0] = pc_q;
    else if (rid == core_pkg::R_STATUS)
    begin
      rd_val[core_pkg::ST_ZERO] = zero_q;
      rd_val[core_pkg::ST_BUSY] = busy;
      rd_val[core_pkg::ST_SQUASH] = squash_q;
      rd_val[core_pkg::ST_SP_LSB +: SP_W] = stk.sp;
    end
    else if (rid == core_pkg::R_FIDX) rd_val[core_pkg::FILE_W-1:0] = fidx_q;
    else if (rid == core_pkg::R_FDATA) rd_val[7:0] = file_mem[fidx_q];
    else if (rid == core_pkg::R_STACK) rd_val[core_pkg::PC_W-1:0] = stk.rd_data;
    else if (rid == core_pkg::R_CYCLES) rd_val = cycles_q;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else if (psel && penable && !pready_q && !stall)
    begin
      pready_q <= 1'b1;
      pslverr_q <= (rid == core_pkg::R_NONE);
      prdata_q <= pwrite ? '0 : rd_val;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode
  assign op = core_pkg::opcode_t'(insn_q[core_pkg::OP_LSB +: core_pkg::OP_W]);
  assign f_addr = insn_q[core_pkg::FILE_LSB +: core_pkg::FILE_W];
  assign f_bit = insn_q[core_pkg::BIT_LSB +: core_pkg::BIT_W];
  // live: executing for real, not the discarded prefetch slot
  assign live = (state_q == core_pkg::S_RUN) && !squash_q;
  assign do_skip = live && (((op == core_pkg::OP_TEST_CLR) && !tbit)
    || ((op == core_pkg::OP_TEST_SET) && tbit));

  bit_select #(.WIDTH(8), .IDX_W(core_pkg::BIT_W)) u_bit (
    .byte_in(file_mem[f_addr]),
    .idx(f_bit),
    .bit_out(tbit)
  );

  return_stack #(.DEPTH(STACK_DEPTH), .SP_W(SP_W)) u_stack (
    .mclk(mclk),
    .rstn(rstn),
    .stk(stk)
  );

  assign stk.push = live && (op == core_pkg::OP_ICALL);
  assign stk.push_data = pc_q + core_pkg::PC_STEP;
  assign stk.rd_idx = fidx_q[SP_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= core_pkg::S_IDLE;
    end
    else
    begin
      case (state_q)
        core_pkg::S_IDLE:
          if (wr_done && rid == core_pkg::R_INSN) state_q <= core_pkg::S_RUN;
        core_pkg::S_RUN:
          // reload costs a second cycle for the flushed fetch
          if (live && op == core_pkg::OP_ICALL) state_q <= core_pkg::S_FLUSH;
          else state_q <= core_pkg::S_IDLE;
        core_pkg::S_FLUSH:
          state_q <= core_pkg::S_IDLE;
        default:
          state_q <= core_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn) insn_q <= '0;
    else if (wr_done && rid == core_pkg::R_INSN) insn_q <= pwdata[core_pkg::INSN_W-1:0];
  end

  // the next instruction fetched after a skip is replaced by a nop
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn) squash_q <= 1'b0;
    else if (do_skip) squash_q <= 1'b1;
    else if (state_q == core_pkg::S_RUN) squash_q <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn) pc_q <= core_pkg::PC_RST;
    else if (live && op == core_pkg::OP_ICALL) pc_q <= {tptr_q[1:0], accum_q};
    else if (state_q == core_pkg::S_RUN) pc_q <= pc_q + core_pkg::PC_STEP;
    else if (wr_done && rid == core_pkg::R_PC) pc_q <= pwdata[core_pkg::PC_W-1:0];
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn) accum_q <= core_pkg::ACCUM_RST;
    else if (live && op == core_pkg::OP_CLRACC) accum_q <= 8'h00;
    else if (wr_done && rid == core_pkg::R_ACCUM) accum_q <= pwdata[7:0];
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn) zero_q <= core_pkg::ZERO_RST;
    else if (live && op == core_pkg::OP_CLRACC) zero_q <= 1'b1;
    else if (wr_done && rid == core_pkg::R_STATUS) zero_q <= pwdata[core_pkg::ST_ZERO];
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn) tptr_q <= core_pkg::TPTR_RST;
    else if (wr_done && rid == core_pkg::R_TPTR) tptr_q <= pwdata[7:0];
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn) fidx_q <= '0;
    else if (wr_done && rid == core_pkg::R_FIDX) fidx_q <= pwdata[core_pkg::FILE_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (wr_done && rid == core_pkg::R_FDATA) file_mem[fidx_q] <= pwdata[7:0];
  end

  // execution cycles, flushed slots included
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn) cycles_q <= '0;
    else if (busy) cycles_q <= cycles_q + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_call_issue;
    live && op == core_pkg::OP_ICALL;
  endsequence

  sequence s_call_done;
    (state_q == core_pkg::S_FLUSH) ##1 (state_q == core_pkg::S_IDLE);
  endsequence

  a_skip_clear: assert property (
    (live && op == core_pkg::OP_TEST_CLR && !tbit) |=> squash_q)
    else $error("clear bit test did not skip");
  a_skip_set: assert property (
    (live && op == core_pkg::OP_TEST_SET) |=> (squash_q == $past(tbit)))
    else $error("set bit test skip wrong");
  a_squash_nop: assert property (
    (state_q == core_pkg::S_RUN && squash_q) |=>
      (accum_q == $past(accum_q)) && (pc_q == $past(pc_q) + core_pkg::PC_STEP) && !squash_q)
    else $error("discarded slot did not act as nop");
  a_test_one_cycle: assert property (
    (live && (op == core_pkg::OP_TEST_CLR || op == core_pkg::OP_TEST_SET)) |=>
      (state_q == core_pkg::S_IDLE) && (pc_q == $past(pc_q) + core_pkg::PC_STEP))
    else $error("bit test did not finish in one cycle");
  a_call_push: assert property (
    s_call_issue |=> (u_stack.mem[$past(stk.sp)] == $past(pc_q) + core_pkg::PC_STEP))
    else $error("call pushed wrong return address");
  a_call_load: assert property (
    s_call_issue |=> (pc_q == {$past(tptr_q[1:0]), $past(accum_q)}))
    else $error("call loaded wrong program counter");
  a_call_flush: assert property (
    s_call_issue |=> s_call_done)
    else $error("call did not flush for one cycle");
  a_clear_accum: assert property (
    (live && op == core_pkg::OP_CLRACC) |=>
      (accum_q == 8'h00) && zero_q && (state_q == core_pkg::S_IDLE))
    else $error("accumulator clear wrong");
  a_bit_pick: assert property (
    (state_q == core_pkg::S_RUN) |-> (tbit == file_mem[f_addr][f_bit]))
    else $error("wrong file bit selected");
  a_nop_exec: assert property (
    (live && !(op inside {core_pkg::OP_TEST_CLR, core_pkg::OP_TEST_SET,
      core_pkg::OP_ICALL, core_pkg::OP_CLRACC})) |=>
      (accum_q == $past(accum_q)) && (pc_q == $past(pc_q) + core_pkg::PC_STEP)
      && (state_q == core_pkg::S_IDLE))
    else $error("plain nop changed state");
  // bus answer: one-cycle ready, writes held off while busy
  a_ready_pulse: assert property (
    pready_q |=> !pready_q)
    else $error("ready stood more than one cycle");
  a_write_stall: assert property (
    (psel && penable && pwrite && busy) |=> !pready_q)
    else $error("write answered while busy");
  a_cycle_count: assert property (
    busy |=> (cycles_q == $past(cycles_q) + 32'h0000_0001))
    else $error("busy cycle not counted");
endmodule // insn_exec
`default_nettype wire

// ---- test/bit_test_skip_and_indirect_call_tb.sv ----
// self-checking bench for the bit-test, indirect-call and clear-accumulator core
`timescale 1ns/1ps
`default_nettype none
module bit_test_skip_and_indirect_call_tb;
  logic mclk;
  logic rstn;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic [core_pkg::APB_AW-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  int error_cnt = 0;
  int total_checks = 0;
  logic [9:0] pc_e;

  insn_exec insn_exec_inst (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  // issue one instruction, then wait until the core is idle again
  task automatic exec(input logic [13:0] w);
    logic [31:0] s;
    int n;
    wr(core_pkg::OFF_INSN, {18'h0, w});
    n = 0;
    do
    begin
      rd(core_pkg::OFF_STATUS, s);
      n++;
    end
    while (s[core_pkg::ST_BUSY] !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      $display("BAD %0t core stuck busy", $time);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] offs[6];
    logic [31:0] d;
    logic e;
    offs = '{core_pkg::OFF_ACCUM, core_pkg::OFF_TPTR, core_pkg::OFF_PC,
      core_pkg::OFF_STATUS, core_pkg::OFF_FIDX, core_pkg::OFF_CYCLES};
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0, d, e);
      check(d, 32'h0, "reset value");
      check({31'h0, e}, 32'h0, "mapped read err");
    end
  endtask

  // opcode 0 and the unused codes 5 to 7 all run as a nop
  task automatic t_nop;
    logic [31:0] d;
    logic [31:0] p;
    wr(core_pkg::OFF_ACCUM, 32'h3c);
    rd(core_pkg::OFF_PC, p);
    for (int k = 0; k < 4; k++)
    begin
      exec({((k == 0) ? 3'h0 : 3'(k + 4)), 11'h7ff});
    end
    rd(core_pkg::OFF_ACCUM, d);
    check(d, 32'h3c, "accumulator after nops");
    rd(core_pkg::OFF_PC, d);
    check(d, 32'(p[9:0] + 10'h4), "pc after nops");
    rd(core_pkg::OFF_STATUS, d);
    check(d, 32'h0, "status after nops");
  endtask

  task automatic t_unmapped;
    logic [31:0] d;
    logic e;
    apb(1'b1, 8'h40, 32'hffffffff, d, e);
    check({31'h0, e}, 32'h1, "unmapped write err");
    apb(1'b0, 8'h40, 32'h0, d, e);
    check({31'h0, e}, 32'h1, "unmapped read err");
    check(d, 32'h0, "unmapped read data");
  endtask

  // every bit of the lowest and highest file register, both test kinds
  task automatic t_bit_tests;
    logic [31:0] d;
    logic [31:0] c;
    logic [5:0] fidx;
    logic [7:0] fval;
    logic skip;
    for (int k = 0; k < 2; k++)
    begin
      fidx = (k == 0) ? 6'h00 : 6'h3f;
      fval = (k == 0) ? 8'h5a : 8'ha5;
      wr(core_pkg::OFF_FIDX, {26'h0, fidx});
      wr(core_pkg::OFF_FDATA, {24'h0, fval});
      for (int op = 1; op < 3; op++)
      begin
        for (int b = 0; b < 8; b++)
        begin
          skip = (op == 1) ? !fval[b] : fval[b];
          wr(core_pkg::OFF_ACCUM, 32'h55);
          wr(core_pkg::OFF_STATUS, 32'h0);
          rd(core_pkg::OFF_PC, d);
          pc_e = d[9:0];
          rd(core_pkg::OFF_CYCLES, c);
          exec({3'(op), 3'(b), 2'b00, fidx});
          rd(core_pkg::OFF_STATUS, d);
          check(32'(d[core_pkg::ST_SQUASH]), 32'(skip), "skip pending");
          exec({3'h4, 11'h0});
          rd(core_pkg::OFF_ACCUM, d);
          check(d, skip ? 32'h55 : 32'h0, "accumulator after next");
          rd(core_pkg::OFF_STATUS, d);
          check(32'(d[core_pkg::ST_ZERO]), 32'(!skip), "zero flag");
          check(32'(d[core_pkg::ST_SQUASH]), 32'h0, "pending cleared");
          rd(core_pkg::OFF_PC, d);
          check(d, 32'(pc_e + 10'h2), "pc after pair");
          rd(core_pkg::OFF_CYCLES, d);
          check(d, c + 32'h2, "busy cycles");
        end
      end
    end
  endtask

  // nine calls so the stack pointer wraps; the first return address carries
  task automatic t_call;
    logic [31:0] d;
    logic [31:0] c;
    logic [2:0] sp;
    logic [7:0] a8;
    wr(core_pkg::OFF_TPTR, 32'hfe);
    wr(core_pkg::OFF_PC, 32'h0ff);
    rd(core_pkg::OFF_STATUS, d);
    sp = d[core_pkg::ST_SP_LSB +: 3];
    for (int i = 0; i < 9; i++)
    begin
      a8 = 8'h30 + 8'(i);
      wr(core_pkg::OFF_ACCUM, {24'h0, a8});
      rd(core_pkg::OFF_PC, d);
      pc_e = d[9:0];
      rd(core_pkg::OFF_CYCLES, c);
      exec({3'h3, 11'h0});
      rd(core_pkg::OFF_PC, d);
      check(d, {22'h0, 2'b10, a8}, "call target");
      rd(core_pkg::OFF_STATUS, d);
      check(32'(d[core_pkg::ST_SP_LSB +: 3]), 32'(3'(sp + 3'h1)), "stack pointer");
      wr(core_pkg::OFF_FIDX, {29'h0, sp});
      rd(core_pkg::OFF_STACK, d);
      check(d, 32'(pc_e + 10'h1), "return address");
      rd(core_pkg::OFF_CYCLES, d);
      check(d, c + 32'h2, "call cycles");
      sp = sp + 3'h1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_nop;
    t_unmapped;
    t_bit_tests;
    t_call;
    results;
  end

  // hang guard, well above the few thousand cycles the tests need
  initial
  begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    results;
  end
endmodule // bit_test_skip_and_indirect_call_tb
`default_nettype wire
